// ---- tppio_pkg.sv ----
// Purpose: shared constants for the three-port parallel io block
// Assumes: 32-bit classic wishbone slave, byte addresses are four times the register index
// Notes:   widths and reset values are named here once
package tppio_pkg;

	// ==========================================================
	// register indices and byte addresses
	localparam logic [3:0] TPPIO_IDX_FIRST_DATA   = 4'h0;
	localparam logic [3:0] TPPIO_IDX_SECOND_DATA  = 4'h1;
	localparam logic [3:0] TPPIO_IDX_NIBBLE_DATA  = 4'h2;
	localparam logic [3:0] TPPIO_IDX_FIRST_DIR    = 4'h4;
	localparam logic [3:0] TPPIO_IDX_SECOND_DIR   = 4'h5;
	localparam logic [3:0] TPPIO_IDX_NIBBLE_DIR   = 4'h6;
	localparam logic [3:0] TPPIO_IDX_CONTROL      = 4'h8;
	localparam int         TPPIO_ADDR_LSB         = 2;
	localparam int         TPPIO_IDX_W            = 4;

	// ==========================================================
	// widths and reset values
	localparam int         TPPIO_WIDE_W           = 8;
	localparam int         TPPIO_NIBBLE_W         = 4;
	localparam logic [7:0] TPPIO_DIR_RESET        = 8'h00;
	localparam logic [7:0] TPPIO_LATCH_INIT       = 8'h00;
	localparam logic [7:0] TPPIO_SHARE_RESET      = 8'h00;
	localparam int         TPPIO_CTRL_HOLD_BIT    = 0;
	localparam int         TPPIO_SYNC_STAGES      = 2;

endpackage

// ---- tppio_sync.sv ----
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: single clock, synchronous reset
// Notes:   stage one is read only by stage two
`timescale 1ns/1ps
module tppio_sync
	import tppio_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	// ==========================================================
	// synchroniser stages
	logic [WIDTH-1:0] meta; // first stage, metastability catcher

	// both stages clear on reset so outputs are defined
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta   <= '0;
			sync_o <= '0;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end

endmodule

// ---- tppio_port.sv ----
// Purpose: one bidirectional port: latch, direction, read mux, pin drive
// Assumes: write strobe and data come from the bus slave on the same clock
// Notes:   latch has no reset on purpose, direction clears on reset
`timescale 1ns/1ps
module tppio_port
	import tppio_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             hold_i,       // low-power hold, freezes pin state
	input  wire logic             data_we_i,    // data register write strobe
	input  wire logic             dir_we_i,     // direction register write strobe
	input  wire logic [WIDTH-1:0] wdata_i,      // write data
	input  wire logic [WIDTH-1:0] share_en_i,   // per bit peripheral takeover
	input  wire logic [WIDTH-1:0] share_dir_i,  // peripheral direction per bit
	input  wire logic [WIDTH-1:0] share_out_i,  // peripheral output per bit
	input  wire logic [WIDTH-1:0] pin_i,        // raw pin level
	output logic      [WIDTH-1:0] pin_o,        // pin drive value
	output logic      [WIDTH-1:0] pin_oe_o,     // pin drive enable
	output logic      [WIDTH-1:0] data_rd_o,    // data register read value
	output logic      [WIDTH-1:0] dir_rd_o,     // direction register read value
	output logic      [WIDTH-1:0] pin_sync_o    // synchronised pin level
);

	// ==========================================================
	// storage
	logic [WIDTH-1:0] latch = TPPIO_LATCH_INIT[WIDTH-1:0]; // output latch, kept over reset
	logic [WIDTH-1:0] dir;                                 // direction, 1 is output
	logic [WIDTH-1:0] pin_s;                               // pin after synchroniser

	tppio_sync #(.WIDTH(WIDTH)) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (pin_i),
		.sync_o  (pin_s)
	);

	// output latch: writes land whatever the direction; reset leaves it alone
	always_ff @(posedge clk_i) begin
		if (data_we_i && !hold_i) begin
			latch <= wdata_i;
		end
	end

	// direction register: cleared on any reset so every pin becomes an input
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir <= TPPIO_DIR_RESET[WIDTH-1:0];
		end else if (dir_we_i && !hold_i) begin
			dir <= wdata_i;
		end
	end

	// ==========================================================
	// per bit pin drive and read mux
	genvar b;
	generate
		for (b = 0; b < WIDTH; b++) begin : g_bit
			// peripheral owns the bit while its enable is set and neither reset nor hold is active
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pin_oe_o[b] <= 1'b0;
					pin_o[b]    <= 1'b0;
				end else if (hold_i) begin
					pin_oe_o[b] <= pin_oe_o[b];
					pin_o[b]    <= pin_o[b];
				end else if (share_en_i[b]) begin
					pin_oe_o[b] <= share_dir_i[b];
					pin_o[b]    <= share_out_i[b];
				end else begin
					pin_oe_o[b] <= dir[b];
					pin_o[b]    <= (data_we_i && dir_we_i) ? latch[b] :
					               (data_we_i ? wdata_i[b] : latch[b]);
				end
			end
			// input bits read the pin, output bits read the latch
			assign data_rd_o[b] = dir[b] ? latch[b] : pin_s[b];
		end
	endgenerate

	assign dir_rd_o   = dir;
	assign pin_sync_o = pin_s;

	// ==========================================================
	// checks
	dir_reset_a: assert property (@(posedge clk_i) rst_i |=> (dir == '0))
		else $error("direction not cleared by reset");
	drive_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!hold_i && !$past(hold_i) && $past(!rst_i) && !$past(share_en_i[0]))
		|-> pin_oe_o[0] == $past(dir[0]))
		else $error("pin enable does not follow direction");
	hold_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(hold_i) && !$past(rst_i) |-> $stable(pin_oe_o) && $stable(pin_o))
		else $error("pins changed while held");

endmodule

// ---- tppio_top.sv ----
// Purpose: three-port parallel io behind a classic wishbone slave
// Assumes: 250 MHz clk_i, synchronous active-high rst_i, 32-bit bus, one cycle ack
// Notes:   two 8-bit ports and one 4-bit port, 20 pins in all
//          registers sit at four times their index: data 0x00/0x04/0x08, direction 0x10/0x14/0x18
//          control word at 0x20, bit zero is a software hold with the same effect as stop_i
//          output latches have no reset: a mid-run reset keeps them, power-up starts them at zero
//          pin inputs cross two flip-flops, so a data read returns the pin as it stood three edges before the ack
//          the serial module owns a second-port bit whenever its enable bit is set and neither reset nor hold is active
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
module tppio_top
	import tppio_pkg::*;
#(
	parameter int WIDE_W   = TPPIO_WIDE_W,
	parameter int NIBBLE_W = TPPIO_NIBBLE_W
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// wishbone classic slave
	input  wire logic                cyc_i,
	input  wire logic                stb_i,
	input  wire logic                we_i,
	input  wire logic [5:0]          adr_i,
	input  wire logic [3:0]          sel_i,
	input  wire logic [31:0]         dat_i,
	output logic      [31:0]         dat_o,
	output logic                     ack_o,
	// low-power stopped state request
	input  wire logic                stop_i,
	// serial peripheral sharing of second port
	input  wire logic [WIDE_W-1:0]   sync_serial_module_en_i,
	input  wire logic [WIDE_W-1:0]   sync_serial_module_dir_i,
	input  wire logic [WIDE_W-1:0]   sync_serial_module_out_i,
	output logic      [WIDE_W-1:0]   sync_serial_module_in_o,
	// pins
	input  wire logic [WIDE_W-1:0]   first_pin_i,
	output logic      [WIDE_W-1:0]   first_pin_o,
	output logic      [WIDE_W-1:0]   first_pin_oe_o,
	input  wire logic [WIDE_W-1:0]   second_pin_i,
	output logic      [WIDE_W-1:0]   second_pin_o,
	output logic      [WIDE_W-1:0]   second_pin_oe_o,
	input  wire logic [NIBBLE_W-1:0] nibble_pin_i,
	output logic      [NIBBLE_W-1:0] nibble_pin_o,
	output logic      [NIBBLE_W-1:0] nibble_pin_oe_o
);

	// ==========================================================
	// bus decode
	logic [TPPIO_IDX_W-1:0] idx;     // register index from byte address
	logic                   req;     // new access this cycle
	logic                   wr;      // write that takes effect now
	logic                   lane0;   // low byte lane enabled
	logic                   hold;    // stopped state freeze
	logic                   ctrl_hold; // software stop hold bit

	// the index drops the two byte-offset bits of the byte address
	assign idx   = adr_i[TPPIO_ADDR_LSB +: TPPIO_IDX_W];
	// a request is new only while the previous one is not being acked
	assign req   = cyc_i && stb_i && !ack_o;
	// only lane zero carries register bits, so a write without it is dropped
	assign lane0 = sel_i[0];
	assign wr    = req && we_i && lane0;
	// either the stop pin or the control bit freezes the pins
	assign hold  = stop_i || ctrl_hold;

	// ack one cycle after the request, dropped the cycle after
	// registering ack costs a cycle but keeps the decode off the bus return path
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req;
		end
	end

	// ==========================================================
	// control register: bit zero forces the hold state
	// the control word itself is never frozen, or software could not leave the hold
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_hold <= 1'b0;
		end else if (wr && idx == TPPIO_IDX_CONTROL) begin
			ctrl_hold <= dat_i[TPPIO_CTRL_HOLD_BIT];
		end
	end

	// ==========================================================
	// three ports
	logic [WIDE_W-1:0]   first_data_rd;    // first port data read
	logic [WIDE_W-1:0]   first_dir_rd;     // first port direction read
	logic [WIDE_W-1:0]   second_data_rd;   // second port data read
	logic [WIDE_W-1:0]   second_dir_rd;    // second port direction read
	logic [NIBBLE_W-1:0] nibble_data_rd;   // nibble port data read
	logic [NIBBLE_W-1:0] nibble_dir_rd;    // nibble port direction read

	// first port shares nothing
	// all three ports are the same module, so per-pin direction works alike on 20 pins
	// share inputs tied low make the takeover path fall away in synthesis
	tppio_port #(.WIDTH(WIDE_W)) u_first (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.hold_i      (hold),
		.data_we_i   (wr && idx == TPPIO_IDX_FIRST_DATA),
		.dir_we_i    (wr && idx == TPPIO_IDX_FIRST_DIR),
		.wdata_i     (dat_i[WIDE_W-1:0]),
		.share_en_i  ({WIDE_W{1'b0}}),
		.share_dir_i ({WIDE_W{1'b0}}),
		.share_out_i ({WIDE_W{1'b0}}),
		.pin_i       (first_pin_i),
		.pin_o       (first_pin_o),
		.pin_oe_o    (first_pin_oe_o),
		.data_rd_o   (first_data_rd),
		.dir_rd_o    (first_dir_rd),
		.pin_sync_o  ()
	);

	// second port lends bits to the serial peripheral
	// the peripheral sees the synchronised pins, the register view stays as usual
	tppio_port #(.WIDTH(WIDE_W)) u_second (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.hold_i      (hold),
		.data_we_i   (wr && idx == TPPIO_IDX_SECOND_DATA),
		.dir_we_i    (wr && idx == TPPIO_IDX_SECOND_DIR),
		.wdata_i     (dat_i[WIDE_W-1:0]),
		.share_en_i  (sync_serial_module_en_i),
		.share_dir_i (sync_serial_module_dir_i),
		.share_out_i (sync_serial_module_out_i),
		.pin_i       (second_pin_i),
		.pin_o       (second_pin_o),
		.pin_oe_o    (second_pin_oe_o),
		.data_rd_o   (second_data_rd),
		.dir_rd_o    (second_dir_rd),
		.pin_sync_o  (sync_serial_module_in_o)
	);

	// nibble port: only low bits of the write data are stored
	// its upper register bits do not exist, so they read zero through the cast below
	tppio_port #(.WIDTH(NIBBLE_W)) u_nibble (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.hold_i      (hold),
		.data_we_i   (wr && idx == TPPIO_IDX_NIBBLE_DATA),
		.dir_we_i    (wr && idx == TPPIO_IDX_NIBBLE_DIR),
		.wdata_i     (dat_i[NIBBLE_W-1:0]),
		.share_en_i  ({NIBBLE_W{1'b0}}),
		.share_dir_i ({NIBBLE_W{1'b0}}),
		.share_out_i ({NIBBLE_W{1'b0}}),
		.pin_i       (nibble_pin_i),
		.pin_o       (nibble_pin_o),
		.pin_oe_o    (nibble_pin_oe_o),
		.data_rd_o   (nibble_data_rd),
		.dir_rd_o    (nibble_dir_rd),
		.pin_sync_o  ()
	);

	// ==========================================================
	// read data, registered with the ack; unmapped reads zero
	// dat_o holds its value between reads, so only the ack cycle is meaningful
	// writes leave dat_o alone to avoid toggling the return bus needlessly
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (req && !we_i) begin
			unique case (idx)
				TPPIO_IDX_FIRST_DATA:  dat_o <= 32'(first_data_rd);
				TPPIO_IDX_SECOND_DATA: dat_o <= 32'(second_data_rd);
				TPPIO_IDX_NIBBLE_DATA: dat_o <= 32'(nibble_data_rd);
				TPPIO_IDX_FIRST_DIR:   dat_o <= 32'(first_dir_rd);
				TPPIO_IDX_SECOND_DIR:  dat_o <= 32'(second_dir_rd);
				TPPIO_IDX_NIBBLE_DIR:  dat_o <= 32'(nibble_dir_rd);
				TPPIO_IDX_CONTROL:     dat_o <= 32'(ctrl_hold);
				default:               dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// bus protocol checks

	// every new request is answered at the very next edge
	ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack not one cycle after request");

	// ack is a pulse, so a held strobe cannot be taken twice
	ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held more than one cycle");

	// no answer without a request one cycle before
	ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");

	// registers are at most one byte wide, the rest of the word reads zero
	read_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o && $past(!we_i) |-> dat_o[31:8] == 24'h00_0000)
		else $error("read data above the low byte not zero");

	// ==========================================================
	// register checks

	// first port direction reads back the value just written
	dir_readback_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && idx == TPPIO_IDX_FIRST_DIR && !hold |=> first_dir_rd == $past(dat_i[7:0]))
		else $error("direction read does not match write");

	// second port direction reads back too
	second_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && idx == TPPIO_IDX_SECOND_DIR && !hold |=> second_dir_rd == $past(dat_i[7:0]))
		else $error("second direction read does not match write");

	// nibble direction keeps only its four low bits
	nibble_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && idx == TPPIO_IDX_NIBBLE_DIR && !hold |=> nibble_dir_rd == $past(dat_i[3:0]))
		else $error("nibble direction read does not match write");

	// nibble direction read clears the unused upper bits
	nibble_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o && $past(idx) == TPPIO_IDX_NIBBLE_DIR && $past(!we_i) |-> dat_o[7:4] == 4'h0)
		else $error("nibble upper bits not zero");

	// the same holds for the nibble data read
	nibble_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o && $past(idx) == TPPIO_IDX_NIBBLE_DATA && $past(!we_i) |-> dat_o[7:4] == 4'h0)
		else $error("nibble data upper bits not zero");

	// write in output mode, then read: the latch comes back, not the pin;
	// the read is taken three edges later because the master idles one cycle
	out_readback_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && idx == TPPIO_IDX_FIRST_DATA && !hold && first_dir_rd == 8'hff
		##3 (cyc_i && stb_i && !we_i && !ack_o && idx == TPPIO_IDX_FIRST_DATA && first_dir_rd == 8'hff)
		|=> dat_o[7:0] == $past(dat_i[7:0], 4))
		else $error("output bits do not read latch");

	// input bits read the pin as it stood three edges before the ack,
	// the two synchroniser stages plus the read edge; skipped just after reset
	input_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o && $past(idx) == TPPIO_IDX_FIRST_DATA && $past(!we_i) && !$past(rst_i, 2) && !$past(rst_i, 3)
		|-> (dat_o[7:0] & ~$past(first_dir_rd)) == ($past(first_pin_i, 3) & ~$past(first_dir_rd)))
		else $error("input bits do not read the pin");

	// a held port ignores direction writes
	hold_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
		hold && wr && idx == TPPIO_IDX_FIRST_DIR |=> first_dir_rd == $past(first_dir_rd))
		else $error("direction changed while held");

	// ==========================================================
	// pin checks

	// reset turns every pin of every port into an input
	pin_reset_a: assert property (@(posedge clk_i)
		rst_i |=> first_pin_oe_o == '0 && second_pin_oe_o == '0 && nibble_pin_oe_o == '0)
		else $error("pin enable left on after reset");

	// a data write shows on the unshared first port at the next edge
	write_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && idx == TPPIO_IDX_FIRST_DATA && !hold |=> first_pin_o == $past(dat_i[7:0]))
		else $error("first port pin not driven by the write");

	// and on the nibble port
	nibble_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && idx == TPPIO_IDX_NIBBLE_DATA && !hold |=> nibble_pin_o == $past(dat_i[3:0]))
		else $error("nibble pin not driven by the write");

	// serial module enable on bit zero hands that pin's drive enable to the peripheral
	share_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!hold && sync_serial_module_en_i[0] |=> second_pin_oe_o[0] == $past(sync_serial_module_dir_i[0]))
		else $error("shared pin not under peripheral control");

	// every second-port bit follows its own enable; the rest keep the register view
	for (genvar s = 0; s < WIDE_W; s++) begin : g_share_chk
		share_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
			!hold && sync_serial_module_en_i[s]
			|=> second_pin_oe_o[s] == $past(sync_serial_module_dir_i[s]))
			else $error("shared pin enable not from peripheral");
		share_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
			!hold && sync_serial_module_en_i[s]
			|=> second_pin_o[s] == $past(sync_serial_module_out_i[s]))
			else $error("shared pin value not from peripheral");
		own_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
			!hold && !sync_serial_module_en_i[s]
			|=> second_pin_oe_o[s] == $past(second_dir_rd[s]))
			else $error("unshared pin enable not from direction");
	end

endmodule

// ---- tppio_pins.sv ----
// Purpose: board-side model of one port's pins
// Assumes: the board drives each pin weakly, the block's enable wins
// Notes:   a released pin shows the board value, never the last drive
`timescale 1ns/1ps
module tppio_pins #(
	parameter int WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] drv_i,  // value driven by the block
	input  wire logic [WIDTH-1:0] oe_i,   // block drive enable
	input  wire logic [WIDTH-1:0] ext_i,  // board level on undriven pins
	output logic      [WIDTH-1:0] lvl_o   // resolved wire level
);
	// ==========================================================
	// wire resolution
	// per bit: a driving block overrides the board's weak source
	always_comb begin
		lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
	end
endmodule

// ---- tb_top.sv ----
// Purpose: self-checking bench for the three-port parallel io block
// Assumes: one-cycle wishbone ack, two-flop pin synchroniser
// Notes:   a queue-free integer model tracks latches and directions
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin error_cnt++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_top;
	import tppio_pkg::*;
	// ==========================================================
	// signals
	logic        clk = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, stop = 0;
	logic [5:0]  adr = 6'h00;
	logic [3:0]  sel = 4'hf, sel_v = 4'hf;
	logic [31:0] dat_w = 32'h0, dat_r, seed = 32'hbb4b;
	logic        ack;
	logic [7:0]  s_en = 8'h00, s_dir = 8'h00, s_out = 8'h00, s_in;
	logic [7:0]  ext [3];        // board levels per port
	wire  [7:0]  drv [3], oe [3], lvl [3];
	logic [7:0]  latm [3], dirm [3], mask [3], rd;  // reference model
	int          error_cnt = 0, comparisons = 0;
	always #2 clk = ~clk;        // 250 MHz
	// ==========================================================
	// block and board
	tppio_top dut (.clk_i(clk), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .stop_i(stop),
		.sync_serial_module_en_i(s_en), .sync_serial_module_dir_i(s_dir),
		.sync_serial_module_out_i(s_out), .sync_serial_module_in_o(s_in),
		.first_pin_i(lvl[0]), .first_pin_o(drv[0]), .first_pin_oe_o(oe[0]),
		.second_pin_i(lvl[1]), .second_pin_o(drv[1]), .second_pin_oe_o(oe[1]),
		.nibble_pin_i(lvl[2][3:0]), .nibble_pin_o(drv[2][3:0]), .nibble_pin_oe_o(oe[2][3:0]));
	tppio_pins #(.WIDTH(8)) pins0 (.drv_i(drv[0]), .oe_i(oe[0]), .ext_i(ext[0]), .lvl_o(lvl[0]));
	tppio_pins #(.WIDTH(8)) pins1 (.drv_i(drv[1]), .oe_i(oe[1]), .ext_i(ext[1]), .lvl_o(lvl[1]));
	tppio_pins #(.WIDTH(4)) pins2 (.drv_i(drv[2][3:0]), .oe_i(oe[2][3:0]), .ext_i(ext[2][3:0]),
		.lvl_o(lvl[2][3:0]));
	// ==========================================================
	// helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// one random byte, cut on purpose from the 32-bit state
	function automatic logic [7:0] xs8();
		logic [31:0] r;
		r = xs();
		return r[7:0];
	endfunction
	task automatic stop_test();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// one classic cycle; waits for ack under a bound, takes data at that edge
	task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; sel <= sel_v; dat_w <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dat_r[7:0];
		if (n >= 20) begin
			error_cnt++;
			stop_test();
		end
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask
	// pin enables and driven values against the model, sharing included
	task automatic chk_pins(input int p);
		logic [7:0] eo, ed;
		eo = (p == 1) ? ((s_en & s_dir) | (~s_en & dirm[1])) : dirm[p];
		ed = (p == 1) ? ((s_en & s_out) | (~s_en & latm[1])) : latm[p];
		`CHK("pin_oe", eo & mask[p], oe[p] & mask[p])
		`CHK("pin_drive", ed & eo & mask[p], drv[p] & oe[p] & mask[p])
	endtask
	task automatic chk_read(input int p);
		wb(1'b0, p[3:0], 8'h00, rd);
		`CHK("data_read", ((ext[p] & ~dirm[p]) | (latm[p] & dirm[p])) & mask[p], rd)
		wb(1'b0, p[3:0] + 4'h4, 8'h00, rd);
		`CHK("dir_read", dirm[p], rd)
	endtask
	// ==========================================================
	// main sequence
	initial begin
		logic [7:0] d, v;
		for (int p = 0; p < 3; p++) begin
			ext[p] = 8'h00; latm[p] = 8'h00; dirm[p] = 8'h00; mask[p] = (p == 2) ? 8'h0f : 8'hff;
		end
		repeat (6) @(posedge clk);
		rst_i <= 1'b0;
		// reset state: every pin is an input
		for (int p = 0; p < 3; p++) begin
			chk_pins(p);
			chk_read(p);
		end
		// random traffic; data is loaded before direction on every port
		for (int i = 0; i < 12; i++) begin
			for (int p = 0; p < 3; p++) begin
				d = xs8(); v = xs8();
				wb(1'b1, p[3:0], d, rd);
				latm[p] = d & mask[p];
				wb(1'b1, p[3:0] + 4'h4, v, rd);
				dirm[p] = v & mask[p];
				ext[p] <= xs8();
				repeat (4) @(posedge clk);
				chk_pins(p);
				chk_read(p);
			end
		end
		// unmapped place reads zero
		wb(1'b0, 4'h3, 8'h00, rd);
		`CHK("unmapped", 8'h00, rd)
		// write with lane 0 off is dropped
		sel_v = 4'he;
		wb(1'b1, 4'h0, ~latm[0], rd);
		sel_v = 4'hf;
		chk_read(0);
		// stop input, then software hold, freeze port writes and pins
		for (int k = 0; k < 2; k++) begin
			if (k == 0) stop <= 1'b1;
			else wb(1'b1, TPPIO_IDX_CONTROL, 8'h01, rd);
			for (int p = 0; p < 3; p++) begin
				wb(1'b1, p[3:0], ~latm[p], rd);
				wb(1'b1, p[3:0] + 4'h4, ~dirm[p], rd);
			end
			repeat (3) @(posedge clk);
			for (int p = 0; p < 3; p++) chk_pins(p);
			if (k == 0) stop <= 1'b0;
			else wb(1'b1, TPPIO_IDX_CONTROL, 8'h00, rd);
		end
		// serial module takes second-port pins bit by bit
		for (int i = 0; i < 6; i++) begin
			s_en <= xs8(); s_dir <= xs8(); s_out <= xs8(); ext[1] <= xs8();
			repeat (5) @(posedge clk);
			chk_pins(1);
			`CHK("share_in", lvl[1], s_in)
		end
		s_en <= 8'h00;
		// reset in mid-run keeps latches, clears directions
		rst_i <= 1'b1;
		repeat (6) @(posedge clk);
		rst_i <= 1'b0;
		for (int p = 0; p < 3; p++) begin
			dirm[p] = 8'h00;
			chk_pins(p);
			wb(1'b1, p[3:0] + 4'h4, 8'hff, rd);
			dirm[p] = mask[p];
			repeat (2) @(posedge clk);
			chk_read(p);
			chk_pins(p);
		end
		// output-mode write drives the pin at once and reads back the latch
		d = xs8();
		wb(1'b1, TPPIO_IDX_FIRST_DATA, d, rd);
		latm[0] = d;
		chk_pins(0);
		chk_read(0);
		stop_test();
	end
	// hang guard
	initial begin
		repeat (50000) @(posedge clk);
		error_cnt++;
		stop_test();
	end
endmodule
